// ---- shf_regs.svh ----
`ifndef SHF_REGS_SVH
`define SHF_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define SHF_OFS_STATUS 4'h0
`define SHF_OFS_MASK 4'h1
`define SHF_OFS_STATE 4'h2
`define SHF_OFS_PERIOD 4'h3
// ****************************************
// status and mask bit positions
// ****************************************
`define SHF_EV_LOCK 0
`define SHF_EV_UV 1
`define SHF_EV_OV 2
`define SHF_EV_OC 3
`define SHF_EV_TSD 4
`define SHF_EV_SLEEP 5
`define SHF_EV_W 6
`define SHF_MASK_RST 6'h00
// ****************************************
// timing: printed figures and clock rate
// ****************************************
`define SHF_CLK_HZ 200000000
`define SHF_DISCH_MS 10
`define SHF_IDLE_MS 565
`define SHF_LOCK_MS 500
`define SHF_RETRY_S 5
`define SHF_SLOW_MHZ 1800
`define SHF_FAST_HZ 2
`define SHF_DISCH_CYC (`SHF_DISCH_MS * (`SHF_CLK_HZ / 1000))
`define SHF_IDLE_CYC (`SHF_IDLE_MS * (`SHF_CLK_HZ / 1000))
`define SHF_LOCK_CYC (`SHF_LOCK_MS * (`SHF_CLK_HZ / 1000))
`define SHF_RETRY_CYC (`SHF_RETRY_S * `SHF_CLK_HZ)
`define SHF_SLOW_CYC ((`SHF_CLK_HZ / `SHF_SLOW_MHZ) * 1000 + 555)
`define SHF_FAST_CYC (`SHF_CLK_HZ / `SHF_FAST_HZ)
`define SHF_RAMP_STEP 4096
`define SHF_GOOD_CYCLES 3'd5
// ****************************************
// drive constants
// ****************************************
`define SHF_ADV_10 8'h07
`define SHF_ADV_25 8'h12
`define SHF_PH_120 8'h55
`define SHF_PH_240 8'hab
`define SHF_MID 8'h80
`endif

// ---- shf_pkg.sv ----
package shf_pkg;
   // main sequencing states
   typedef enum logic [2:0] {
      ST_SLEEP = 3'b000,
      ST_IDLE = 3'b001,
      ST_DISCH = 3'b010,
      ST_RUN = 3'b011,
      ST_LOCK = 3'b100
   } shf_state_t;
   // three-level selector decode: 00 low, 01 middle, 10 high
   typedef logic [1:0] shf_lvl3_t;
endpackage

// ---- shf_fan_ctrl.sv ----
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "shf_regs.svh"
// Operation
// - discharge soft-start 10 ms, then charge
// - duty widens with speed command level
// - carrier compared against sine drive profile
// - command above threshold: active, hall powered
// - idle, slow hall: hall supply off
// - no hall 565 ms, low command: idle
// - sleep rise: all off, regulator off
// - speed pulse divides hall by 1/2/3
// - phase advance 0, 10 or 25 degrees
// - advance follows rotation direction
// - direction low forward, high reverse
// - no hall 0.5 s: brake, alarm, retry 5 s
// - lock cleared: fast hall, wake, power
// - undervoltage off, release at 5 V
// - overvoltage brakes outputs
// - overcurrent brakes outputs
// - thermal off, release below 135 C
module shf_fan_ctrl
#(
   parameter int unsigned DISCH_CYC = `SHF_DISCH_CYC,
   parameter int unsigned IDLE_CYC = `SHF_IDLE_CYC,
   parameter int unsigned LOCK_CYC = `SHF_LOCK_CYC,
   parameter int unsigned RETRY_CYC = `SHF_RETRY_CYC,
   parameter int unsigned SLOW_CYC = `SHF_SLOW_CYC,
   parameter int unsigned FAST_CYC = `SHF_FAST_CYC
)
(
   input wire logic clk, // 200 MHz
   input wire logic rst, // sync, active high
   input wire logic [3:0] reg_addr, // register index
   input wire logic [15:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [15:0] reg_rdata, // read data, cycle after strobe
   output logic irq, // level interrupt
   input wire logic hall_cmp, // hall comparator output
   input wire logic [7:0] speed_command_level, // digitised command
   input wire logic cmd_above_thr, // command at/above 0.55 V
   input wire logic sleep_pin, // sleep request
   input wire logic direction_select, // low fwd, high rev
   input wire shf_pkg::shf_lvl3_t pulse_divide_select, // 1/3,1/2,1
   input wire shf_pkg::shf_lvl3_t phase_advance_select, // 0/10/25
   input wire logic supply_le_4v, // supply at/below 4 V
   input wire logic supply_ge_5v, // supply at/above 5 V
   input wire logic supply_gt_27v6, // supply above 27.6 V
   input wire logic current_sense_input, // sense at/above 0.25 V
   input wire logic temp_gt_160, // junction above 160 C
   input wire logic temp_lt_135, // junction below 135 C
   output logic [2:0] phase_hi_on, // high sides U,V,W
   output logic [2:0] phase_lo_on, // low sides U,V,W
   output logic hall_sensor_supply, // hall bias enable
   output logic internal_regulator_out, // regulator enable
   output logic speed_pulse_out, // divided speed pulse
   output logic lock_alarm_n, // low while locked
   output logic soft_start_discharge, // 2 mA sink on
   output logic soft_start_charge // 1 uA source on
);
   import shf_pkg::*;

   // ****************************************
   // input synchronisers
   // ****************************************
   localparam int SW = 22;
   logic [SW-1:0] s1_q, s2_q;
   wire [SW-1:0] async_in = {hall_cmp, speed_command_level, cmd_above_thr,
      sleep_pin, direction_select, pulse_divide_select, phase_advance_select,
      supply_le_4v, supply_ge_5v, supply_gt_27v6, current_sense_input,
      temp_gt_160, temp_lt_135};
   // two flops before any logic looks at a pin
   always_ff @(posedge clk)
   begin
      s1_q <= async_in;
      s2_q <= s1_q;
   end
   wire hall = s2_q[21];
   wire [7:0] cmd = s2_q[20:13];
   wire cmd_hi = s2_q[12];
   wire slp = s2_q[11];
   wire rev = s2_q[10];
   wire [1:0] fdiv = s2_q[9:8];
   wire [1:0] adv_sel = s2_q[7:6];
   wire uv_on = s2_q[5];
   wire uv_off = s2_q[4];
   wire ov = s2_q[3];
   wire oc = s2_q[2];
   wire t_hot = s2_q[1];
   wire t_cool = s2_q[0];

   // ****************************************
   // functions
   // ****************************************
   // parabolic half-wave sine scaled by level, centred on mid-scale
   function automatic logic [7:0] shf_wave(input logic [7:0] ang,
      input logic [7:0] lvl);
      logic [13:0] p;
      logic [7:0] s;
      logic [15:0] m;
      p = {7'h00, ang[6:0]} * (14'h0080 - {7'h00, ang[6:0]});
      s = (p[12:5] > 8'h7f) ? 8'h7f : p[12:5];
      m = s * lvl;
      return ang[7] ? (`SHF_MID - m[15:8]) : (`SHF_MID + m[15:8]);
   endfunction
   // saturating 32-bit increment
   function automatic logic [31:0] shf_inc(input logic [31:0] v);
      return (v == 32'hffffffff) ? v : v + 32'h00000001;
   endfunction

   // ****************************************
   // state and protection flags
   // ****************************************
   shf_state_t st_q, st_d;
   logic hall_prev_q, slp_prev_q, uv_q, tsd_q, hpwr_q;
   logic [31:0] idle_q, per_q, tmr_q;
   logic [2:0] good_q;
   logic [7:0] ramp_q;
   logic [12:0] rstep_q;
   wire hall_rise = hall & ~hall_prev_q;
   wire hall_edge = hall ^ hall_prev_q;
   wire slp_rise = slp & ~slp_prev_q;
   wire slp_fall = ~slp & slp_prev_q;
   wire uv_release = uv_q & uv_off;
   wire fast_cycle = hall_rise & (idle_q <= FAST_CYC);
   wire tmr_done_d = (tmr_q >= DISCH_CYC - 1);
   wire tmr_done_r = (tmr_q >= RETRY_CYC - 1);
   wire no_hall_lock = (idle_q >= LOCK_CYC);
   wire no_hall_idle = (idle_q > IDLE_CYC);

   // sequencing: sleep, idle, discharge, run, lock
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         ST_SLEEP:
            if (slp_fall | uv_release)
               st_d = cmd_hi ? ST_DISCH : ST_IDLE;
         ST_IDLE:
            if (cmd_hi)
               st_d = ST_DISCH;
         ST_DISCH:
            if (tmr_done_d)
               st_d = ST_RUN;
         ST_RUN:
            if (no_hall_idle & ~cmd_hi)
               st_d = ST_IDLE;
            else if (no_hall_lock & cmd_hi)
               st_d = ST_LOCK;
         ST_LOCK:
            if (good_q == `SHF_GOOD_CYCLES)
               st_d = ST_RUN;
            else if (no_hall_idle & ~cmd_hi)
               st_d = ST_IDLE;
            else if (tmr_done_r)
               st_d = ST_DISCH;
         default:
            st_d = ST_IDLE;
      endcase
      if (slp_rise)
         st_d = ST_SLEEP;
      else if (uv_release & st_q != ST_SLEEP)
         st_d = cmd_hi ? ST_DISCH : ST_IDLE;
   end

   // state register and phase timer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= ST_IDLE;
         tmr_q <= 32'h00000000;
      end
      else
      begin
         st_q <= st_d;
         tmr_q <= (st_d != st_q) ? 32'h00000000 : shf_inc(tmr_q);
      end
   end

   // edge history, hall period and time since last hall rise
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hall_prev_q <= 1'b0;
         slp_prev_q <= 1'b0;
         idle_q <= 32'h00000000;
         per_q <= 32'hffffffff;
      end
      else
      begin
         hall_prev_q <= hall;
         slp_prev_q <= slp;
         idle_q <= hall_rise ? 32'h00000000 : shf_inc(idle_q);
         if (hall_rise)
            per_q <= idle_q;
      end
   end

   // fast cycle counter that releases a lock
   always_ff @(posedge clk)
   begin
      if (rst | st_q != ST_LOCK)
         good_q <= 3'h0;
      else if (hall_rise)
         good_q <= fast_cycle ? good_q + 3'h1 : 3'h0;
   end

   // undervoltage and thermal hysteresis latches
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         uv_q <= 1'b0;
         tsd_q <= 1'b0;
      end
      else
      begin
         if (uv_on)
            uv_q <= 1'b1;
         else if (uv_off)
            uv_q <= 1'b0;
         if (t_hot)
            tsd_q <= 1'b1;
         else if (t_cool)
            tsd_q <= 1'b0;
      end
   end

   // hall sensor supply control
   always_ff @(posedge clk)
   begin
      if (rst)
         hpwr_q <= 1'b1;
      else if (st_d == ST_SLEEP)
         hpwr_q <= 1'b0;
      else if (cmd_hi)
         hpwr_q <= 1'b1;
      else if (st_q == ST_IDLE & idle_q >= SLOW_CYC)
         hpwr_q <= 1'b0;
   end

   // soft-start ramp: reset in discharge, climbs while running
   always_ff @(posedge clk)
   begin
      if (rst | st_q == ST_DISCH)
      begin
         ramp_q <= 8'h00;
         rstep_q <= 13'h0000;
      end
      else if (st_q == ST_RUN & ramp_q != 8'hff)
      begin
         rstep_q <= (rstep_q == 13'(`SHF_RAMP_STEP - 1)) ? 13'h0000 : rstep_q + 13'h0001;
         if (rstep_q == 13'(`SHF_RAMP_STEP - 1))
            ramp_q <= ramp_q + 8'h01;
      end
   end

   // ****************************************
   // angle interpolation and carrier
   // ****************************************
   logic [7:0] ang_q, car_q;
   logic [23:0] sub_q;
   logic car_up_q;
   wire [23:0] step_len = per_q[31:8];
   wire step_hit = (sub_q >= step_len);
   // angle restarts at every hall rise, steps per 1/256 period
   always_ff @(posedge clk)
   begin
      if (rst | hall_rise)
      begin
         ang_q <= 8'h00;
         sub_q <= 24'h000000;
      end
      else
      begin
         sub_q <= step_hit ? 24'h000000 : sub_q + 24'h000001;
         if (step_hit & ang_q != 8'hff)
            ang_q <= ang_q + 8'h01;
      end
   end

   // triangular carrier, one up/down sweep per pwm period
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         car_q <= 8'h00;
         car_up_q <= 1'b1;
      end
      else
      begin
         car_q <= car_up_q ? car_q + 8'h01 : car_q - 8'h01;
         if (car_up_q & car_q == 8'hfe)
            car_up_q <= 1'b0;
         else if (~car_up_q & car_q == 8'h01)
            car_up_q <= 1'b1;
      end
   end

   // advance amount, signed by direction
   wire [7:0] adv = (adv_sel == 2'b10) ? `SHF_ADV_25 :
      (adv_sel == 2'b01) ? `SHF_ADV_10 : 8'h00;
   wire [7:0] ang_u = rev ? ang_q - adv : ang_q + adv;
   wire [7:0] ang_v = rev ? ang_u - `SHF_PH_240 : ang_u - `SHF_PH_120;
   wire [7:0] ang_w = rev ? ang_u - `SHF_PH_120 : ang_u - `SHF_PH_240;
   // command level limited by the soft-start ramp
   wire [7:0] lvl = (cmd < ramp_q) ? cmd : ramp_q;
   wire [7:0] dr_u = shf_wave(ang_u, lvl);
   wire [7:0] dr_v = shf_wave(ang_v, lvl);
   wire [7:0] dr_w = shf_wave(ang_w, lvl);
   wire [2:0] pwm = {dr_w > car_q, dr_v > car_q, dr_u > car_q};

   // ****************************************
   // output override priority
   // ****************************************
   wire all_off = (st_q == ST_SLEEP) | uv_q | tsd_q;
   wire brake = ov | oc | (st_q != ST_RUN);
   wire [2:0] hi_d = all_off ? 3'b000 : brake ? 3'b000 : pwm;
   wire [2:0] lo_d = all_off ? 3'b000 : brake ? 3'b111 : ~pwm;

   // ****************************************
   // speed pulse divider
   // ****************************************
   logic [2:0] half_q;
   wire [2:0] n_div = (fdiv == 2'b10) ? 3'd1 : (fdiv == 2'b01) ? 3'd2 : 3'd3;
   wire [2:0] half_last = {n_div[1:0], 1'b0} - 3'd1;
   // count hall half cycles; pulse high for first n of 2n
   always_ff @(posedge clk)
   begin
      if (rst)
         half_q <= 3'h0;
      else if (hall_edge)
         half_q <= (half_q >= half_last) ? 3'h0 : half_q + 3'h1;
   end

   // ****************************************
   // registered outputs
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         phase_hi_on <= 3'b000;
         phase_lo_on <= 3'b000;
         hall_sensor_supply <= 1'b0;
         internal_regulator_out <= 1'b0;
         speed_pulse_out <= 1'b0;
         lock_alarm_n <= 1'b1;
         soft_start_discharge <= 1'b0;
         soft_start_charge <= 1'b0;
      end
      else
      begin
         phase_hi_on <= hi_d;
         phase_lo_on <= lo_d;
         hall_sensor_supply <= hpwr_q & (st_q != ST_SLEEP);
         internal_regulator_out <= (st_q != ST_SLEEP);
         speed_pulse_out <= (half_q < n_div);
         lock_alarm_n <= (st_q != ST_LOCK);
         soft_start_discharge <= (st_q == ST_DISCH);
         soft_start_charge <= (st_q == ST_RUN);
      end
   end

   // ****************************************
   // event status, mask and interrupt
   // ****************************************
   logic [`SHF_EV_W-1:0] stat_q, mask_q, ev_prev_q;
   wire [`SHF_EV_W-1:0] ev_lvl = {st_q == ST_SLEEP, tsd_q, oc, ov, uv_q,
      st_q == ST_LOCK};
   wire [`SHF_EV_W-1:0] ev_set = ev_lvl & ~ev_prev_q;
   wire rd_stat = reg_rd & (reg_addr == `SHF_OFS_STATUS);
   wire wr_mask = reg_wr & (reg_addr == `SHF_OFS_MASK);
   // sticky bits; a new event wins over a clearing read
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stat_q <= '0;
         mask_q <= `SHF_MASK_RST;
         ev_prev_q <= '0;
         irq <= 1'b0;
      end
      else
      begin
         ev_prev_q <= ev_lvl;
         stat_q <= (rd_stat ? '0 : stat_q) | ev_set;
         if (wr_mask)
            mask_q <= reg_wdata[`SHF_EV_W-1:0];
         irq <= |(((rd_stat ? '0 : stat_q) | ev_set) & mask_q);
      end
   end

   // ****************************************
   // register read port
   // ****************************************
   wire [15:0] state_word = {7'h00, uv_q, tsd_q, hpwr_q, rev, ov, oc,
      st_q};
   wire [15:0] rd_mux =
      (reg_addr == `SHF_OFS_STATUS) ? {10'h000, stat_q} :
      (reg_addr == `SHF_OFS_MASK) ? {10'h000, mask_q} :
      (reg_addr == `SHF_OFS_STATE) ? state_word :
      (reg_addr == `SHF_OFS_PERIOD) ? per_q[31:16] : 16'h0000;
   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
   end
endmodule // shf_fan_ctrl

// ---- shf_fan_ctrl_chk.sv ----
`timescale 1ns/100ps
// ********
// port checker
// ********
module shf_fan_ctrl_chk
#(
   parameter int unsigned DISCH_CYC = 200,
   parameter int unsigned RETRY_CYC = 2000
)
(
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire logic sleep_pin, // sleep request
   input wire logic cmd_above_thr, // command flag
   input wire logic supply_le_4v, // undervoltage
   input wire logic supply_gt_27v6, // overvoltage
   input wire logic current_sense_input, // overcurrent
   input wire logic temp_gt_160, // overtemperature
   input wire logic [2:0] phase_hi_on, // high sides
   input wire logic [2:0] phase_lo_on, // low sides
   input wire logic hall_sensor_supply, // hall bias
   input wire logic internal_regulator_out, // regulator
   input wire logic lock_alarm_n, // lock alarm
   input wire logic soft_start_discharge, // discharge
   input wire logic soft_start_charge // charge
);
   logic [31:0] dcnt_q;
   logic [31:0] lcnt_q;
   logic all_off;
   logic braked;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // output patterns
   assign all_off = (phase_hi_on == 3'h0) && (phase_lo_on == 3'h0);
   assign braked = (phase_hi_on == 3'h0) && (phase_lo_on == 3'h7);
   // lengths of discharge and lock spells
   always_ff @(posedge clk)
   begin
      dcnt_q <= (rst || !soft_start_discharge) ? 32'h0 : dcnt_q + 32'h1;
      lcnt_q <= (rst || lock_alarm_n) ? 32'h0 : lcnt_q + 32'h1;
   end
   a_no_shoot_thru: assert property ((phase_hi_on & phase_lo_on) == 3'h0)
      else $error("high and low side on together");
   a_sleep_all_off: assert property ($rose(sleep_pin) ##1 sleep_pin [*5] |->
      all_off && !internal_regulator_out) else $error("sleep did not shut down");
   a_uv_all_off: assert property (supply_le_4v [*5] |-> all_off)
      else $error("undervoltage left outputs on");
   a_tsd_all_off: assert property (temp_gt_160 [*5] |-> all_off)
      else $error("overtemperature left outputs on");
   a_ov_brake: assert property (supply_gt_27v6 [*5] |-> braked || all_off)
      else $error("overvoltage without brake");
   a_oc_brake: assert property (current_sense_input [*5] |-> braked || all_off)
      else $error("overcurrent without brake");
   a_lock_brake: assert property ($fell(lock_alarm_n) |-> ##[0:2] braked)
      else $error("lock without brake");
   a_retry_bound: assert property (lcnt_q <= RETRY_CYC + 8)
      else $error("lock outlived retry time");
   a_disch_len: assert property ($fell(soft_start_discharge) && soft_start_charge |->
      dcnt_q >= DISCH_CYC - 1 && dcnt_q <= DISCH_CYC + 1) else $error("discharge length");
   a_ramp_excl: assert property (!(soft_start_discharge && soft_start_charge))
      else $error("charge and discharge together");
   a_hall_power: assert property ($rose(cmd_above_thr) ##1 cmd_above_thr [*5] ##0
      internal_regulator_out |-> hall_sensor_supply) else $error("hall bias off");
   c_lock: cover property ($fell(lock_alarm_n));
   c_sleep: cover property ($rose(sleep_pin) ##1 sleep_pin [*5]);
   c_start: cover property ($fell(soft_start_discharge) && soft_start_charge);
   c_ov: cover property (supply_gt_27v6 [*5]);
endmodule // shf_fan_ctrl_chk

bind shf_fan_ctrl shf_fan_ctrl_chk #(.DISCH_CYC(DISCH_CYC), .RETRY_CYC(RETRY_CYC))
   shf_fan_ctrl_chk_i (.clk(clk), .rst(rst), .sleep_pin(sleep_pin),
   .cmd_above_thr(cmd_above_thr), .supply_le_4v(supply_le_4v),
   .supply_gt_27v6(supply_gt_27v6), .current_sense_input(current_sense_input),
   .temp_gt_160(temp_gt_160), .phase_hi_on(phase_hi_on), .phase_lo_on(phase_lo_on),
   .hall_sensor_supply(hall_sensor_supply), .internal_regulator_out(internal_regulator_out),
   .lock_alarm_n(lock_alarm_n), .soft_start_discharge(soft_start_discharge),
   .soft_start_charge(soft_start_charge));

// ---- shf_motor_model.sv ----
`timescale 1ns/100ps
// ********
// fan motor with one hall sensor
// ********
module shf_motor_model
(
   input wire logic clk, // system clock
   input wire logic powered, // hall bias present
   input wire logic spin, // rotor turning
   input wire logic [15:0] half, // half hall period in cycles
   output logic hall_cmp // comparator level
);
   logic [15:0] cnt_q = 16'h0;
   logic hall_q = 1'b0;
   // unbiased or stalled sensor rests low behind the comparator pull-down
   always_ff @(posedge clk)
   begin
      if (!powered || !spin)
      begin
         cnt_q <= 16'h0;
         hall_q <= 1'b0;
      end
      else if (cnt_q >= half - 16'h1)
      begin
         cnt_q <= 16'h0;
         hall_q <= !hall_q;
      end
      else
         cnt_q <= cnt_q + 16'h1;
   end
   assign hall_cmp = hall_q;
endmodule // shf_motor_model

// ---- shf_fan_ctrl_bench.sv ----
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
   $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
// ********
// bench
// ********
module shf_fan_ctrl_bench;
   import shf_pkg::*;
   localparam int unsigned DISCH = 200, LOCK = 1000, RETRY = 2000, IDLE = 1130, SLOW = 1111;
   logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, hall_cmp, irq;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0, reg_rdata, d;
   logic [7:0] speed_command_level = 8'h40;
   logic cmd_above_thr = 1'b0, sleep_pin = 1'b0, direction_select = 1'b0;
   shf_lvl3_t pulse_divide_select = 2'h0, phase_advance_select = 2'h0;
   logic supply_le_4v = 1'b0, supply_ge_5v = 1'b1, supply_gt_27v6 = 1'b0;
   logic current_sense_input = 1'b0, temp_gt_160 = 1'b0, temp_lt_135 = 1'b1;
   logic [2:0] phase_hi_on, phase_lo_on;
   logic hall_sensor_supply, internal_regulator_out, speed_pulse_out, lock_alarm_n;
   logic soft_start_discharge, soft_start_charge, spin = 1'b0;
   int err_total = 0, comparisons = 0, cyc = 0, n, k;
   int fgexp [4] = '{3, 2, 1, 3};
   always #2.5 clk = ~clk;
   shf_fan_ctrl #(.DISCH_CYC(DISCH), .IDLE_CYC(IDLE), .LOCK_CYC(LOCK), .RETRY_CYC(RETRY),
      .SLOW_CYC(SLOW), .FAST_CYC(1000)) shf_fan_ctrl_i (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .hall_cmp(hall_cmp),
      .speed_command_level(speed_command_level), .cmd_above_thr(cmd_above_thr),
      .sleep_pin(sleep_pin), .direction_select(direction_select),
      .pulse_divide_select(pulse_divide_select), .phase_advance_select(phase_advance_select),
      .supply_le_4v(supply_le_4v), .supply_ge_5v(supply_ge_5v), .supply_gt_27v6(supply_gt_27v6),
      .current_sense_input(current_sense_input), .temp_gt_160(temp_gt_160),
      .temp_lt_135(temp_lt_135), .phase_hi_on(phase_hi_on), .phase_lo_on(phase_lo_on),
      .hall_sensor_supply(hall_sensor_supply), .internal_regulator_out(internal_regulator_out),
      .speed_pulse_out(speed_pulse_out), .lock_alarm_n(lock_alarm_n),
      .soft_start_discharge(soft_start_discharge), .soft_start_charge(soft_start_charge));
   shf_motor_model shf_motor_model_i (.clk(clk), .powered(hall_sensor_supply), .spin(spin),
      .half(16'd100), .hall_cmp(hall_cmp));
   // register access, read data taken at the edge closing the cycle after the strobe
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
   endtask
   task automatic waitv(ref logic s, input logic v, output int c);
      c = 0;
      while (s !== v && c < 5000)
      begin
         @(posedge clk);
         c++;
      end
      `CHK("wait limit", 1'b1, c < 5000)
   endtask
   // hall rises within one speed pulse cycle
   task automatic fgcount(output int c);
      logic ph, ps;
      waitv(speed_pulse_out, 1'b0, c);
      waitv(speed_pulse_out, 1'b1, c);
      c = 0; ps = 1'b1; ph = hall_cmp;
      for (int i = 0; i < 5000; i++)
      begin
         @(posedge clk);
         if (hall_cmp && !ph) c++;
         ph = hall_cmp;
         if (speed_pulse_out && !ps) break;
         ps = speed_pulse_out;
      end
   endtask
   task conclude();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 40000)
      begin
         err_total++;
         conclude();
      end
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1 `CHK("reset out", 6'h07, {phase_hi_on, phase_lo_on})
      `CHK("alarm", 1'b1, lock_alarm_n)
      rd(4'h1, d);
      `CHK("mask", 16'h0000, d)
      rd(4'hf, d);
      `CHK("unmapped", 16'h0000, d)
      wr(4'h1, 16'h003f);
      wr(4'h2, 16'h0007);
      rd(4'h2, d);
      `CHK("idle", 3'h1, d[2:0])
      cmd_above_thr <= 1'b1;
      speed_command_level <= 8'hc8;
      waitv(soft_start_discharge, 1'b1, n);
      waitv(soft_start_discharge, 1'b0, n);
      `CHK("discharge", 1'b1, n >= DISCH - 2 && n <= DISCH + 2)
      `CHK("charge", 1'b1, soft_start_charge)
      `CHK("hall on", 1'b1, hall_sensor_supply)
      spin <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         pulse_divide_select <= i[1:0];
         phase_advance_select <= i[1:0];
         direction_select <= i[0];
         fgcount(k);
         fgcount(k);
         `CHK("fg ratio", fgexp[i], k)
         rd(4'h2, d);
         `CHK("reverse", i[0], d[5])
      end
      spin <= 1'b0;
      waitv(lock_alarm_n, 1'b0, n);
      `CHK("lock time", 1'b1, n >= LOCK - 210 && n <= LOCK + 10)
      repeat (3) @(posedge clk);
      #1 `CHK("lock brake", 6'h07, {phase_hi_on, phase_lo_on})
      `CHK("irq", 1'b1, irq)
      rd(4'h0, d);
      `CHK("lock event", 1'b1, d[0])
      @(posedge clk);
      #1 `CHK("irq clear", 1'b0, irq)
      waitv(lock_alarm_n, 1'b1, n);
      `CHK("retry", 1'b1, n >= RETRY - 20 && n <= RETRY + 10)
      waitv(lock_alarm_n, 1'b0, n);
      spin <= 1'b1;
      waitv(lock_alarm_n, 1'b1, n);
      `CHK("fast clear", 1'b1, n <= 1300)
      for (int i = 1; i < 3; i++)
      begin
         {current_sense_input, supply_gt_27v6} <= 2'(i);
         repeat (8) @(posedge clk);
         #1 `CHK("brake", 6'h07, {phase_hi_on, phase_lo_on})
         @(posedge clk);
         {current_sense_input, supply_gt_27v6} <= 2'h0;
         repeat (8) @(posedge clk);
      end
      supply_le_4v <= 1'b1;
      supply_ge_5v <= 1'b0;
      repeat (8) @(posedge clk);
      #1 `CHK("uv off", 6'h00, {phase_hi_on, phase_lo_on})
      @(posedge clk);
      supply_le_4v <= 1'b0;
      rd(4'h2, d);
      `CHK("uv held", 1'b1, d[8])
      supply_ge_5v <= 1'b1;
      repeat (8) @(posedge clk);
      rd(4'h2, d);
      `CHK("uv release", 1'b0, d[8])
      temp_gt_160 <= 1'b1;
      temp_lt_135 <= 1'b0;
      repeat (8) @(posedge clk);
      #1 `CHK("tsd off", 6'h00, {phase_hi_on, phase_lo_on})
      @(posedge clk);
      temp_gt_160 <= 1'b0;
      rd(4'h2, d);
      `CHK("tsd held", 1'b1, d[7])
      temp_lt_135 <= 1'b1;
      repeat (8) @(posedge clk);
      rd(4'h2, d);
      `CHK("tsd release", 1'b0, d[7])
      rd(4'h0, d);
      `CHK("events", 4'hf, d[4:1])
      sleep_pin <= 1'b1;
      repeat (6) @(posedge clk);
      #1 `CHK("sleep off", 7'h00, {internal_regulator_out, phase_hi_on, phase_lo_on})
      rd(4'h2, d);
      `CHK("sleep", 3'h0, d[2:0])
      sleep_pin <= 1'b0;
      repeat (8) @(posedge clk);
      rd(4'h2, d);
      `CHK("wake", 3'h2, d[2:0])
      `CHK("reg on", 1'b1, internal_regulator_out)
      rd(4'h0, d);
      `CHK("sleep event", 1'b1, d[5])
      cmd_above_thr <= 1'b0;
      spin <= 1'b0;
      repeat (DISCH + IDLE + SLOW + 300) @(posedge clk);
      #1 `CHK("idle brake", 6'h07, {phase_hi_on, phase_lo_on})
      `CHK("hall off", 1'b0, hall_sensor_supply)
      rd(4'h2, d);
      `CHK("idle again", 3'h1, d[2:0])
      wr(4'h1, 16'h0000);
      supply_gt_27v6 <= 1'b1;
      repeat (8) @(posedge clk);
      supply_gt_27v6 <= 1'b0;
      #1 `CHK("masked", 1'b0, irq)
      wr(4'h1, 16'h0004);
      repeat (2) @(posedge clk);
      #1 `CHK("unmasked", 1'b1, irq)
      rd(4'h0, d);
      `CHK("ov event", 1'b1, d[2])
      @(posedge clk);
      #1 `CHK("irq cleared", 1'b0, irq)
      conclude();
   end
endmodule // shf_fan_ctrl_bench
